// ==== rtl/acr_config_regs.sv ====
// configuration registers 0 and 1 with front-end, modulator and sequencer decode
// Functional notes
// R1 - decode input pairs, reset 0 vs 1
// R2 - monitor codes route ref/supply quarter, bypass amplifier
// R3 - host sets skip, gains 1-4 for ground
// R4 - gain code is power of two
// R5 - skipped amplifier uses switched-capacitor gain
// R6 - skip bit bypasses amplifier only gains 1-4
// R7 - rate code read per operating mode
// R8 - mode field: normal, duty, turbo, reserved
// R9 - bit 2 selects continuous conversion
// R10 - temperature mode ignores register 0, internal reference
// R11 - bit 0 turns burn-out sources on
// R12 - all fields read/write, reset zero
// R13 - access only by commands, kept in power-down
// R14 - write applies at command's last edge
// R15 - write command end restarts filter, conversions
// R16 - rate table, quarter in duty, double turbo
// R17 - reserved codes stored, never used as selection
`timescale 1ns/1ps
module acr_config_regs
(
    input wire logic i_sys_clk,                  // 200 MHz system clock
    input wire logic i_reset,                    // synchronous reset, active high
    input wire logic i_clk_en,                   // freezes all state while low, but i_reset still clears it
    input wire logic i_wr_en,                    // byte write, at last serial falling edge
    input wire logic [1:0] i_wr_addr,            // register address of the byte
    input wire logic [7:0] i_wr_data,            // byte to store
    input wire logic i_wr_cmd_done,              // register_write_cmd fully clocked in
    input wire logic [1:0] i_rd_addr,            // register_read_cmd address
    output logic [7:0] o_rd_data,                // registered read data
    output logic [2:0] o_positive_input,         // positive input index
    output logic [2:0] o_negative_input,         // negative input, 4 = analog ground
    output logic o_mon_reference,                // reference / 4 monitor
    output logic o_mon_analog_supply,            // analog supply / 4 monitor
    output logic o_input_valid,                  // front end connected
    output logic [2:0] o_gain_code,              // effective gain code
    output logic [7:0] o_gain_factor,            // effective gain 1..128
    output logic o_lna_enable,                   // low_noise_amplifier powered and used
    output logic o_sc_gain_enable,               // switched-capacitor stage does the gain
    output logic o_temp_sensor_enable,           // temperature sensor mode
    output logic o_internal_ref_force,           // internal reference forced
    output logic o_burnout_source_on,            // 10 uA burn-out sources on
    output logic o_continuous_select,            // continuous conversions
    output logic [1:0] o_op_mode,                // operating mode code
    output logic o_mode_valid,                   // mode code not reserved
    output logic [9:0] o_mod_clk_khz,            // modulator clock in kHz
    output logic o_duty_cycle,                   // one quarter duty operation
    output logic [2:0] o_rate_select,            // rate code
    output logic o_rate_valid,                   // rate code and mode defined
    output logic [13:0] o_rate_qsps,             // output rate in quarter samples/s
    output logic o_filter_restart                // one-cycle filter reset and restart
);
    import acr_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0] input_gain_config;
        logic [7:0] rate_mode_config;
        logic [7:0] rd_data;
        logic [2:0] pos;
        logic [2:0] neg;
        logic mon_ref;
        logic mon_sup;
        logic in_valid;
        logic [2:0] gain;
        logic [7:0] gain_factor;
        logic lna_en;
        logic sc_en;
        logic [1:0] mode;
        logic mode_valid;
        logic [9:0] mod_khz;
        logic duty;
        logic rate_valid;
        logic [13:0] rate_qsps;
        logic restart;
    } acr_state_t;

    acr_state_t state;
    acr_state_t next_state;

    logic [2:0] dec_pos;
    logic [2:0] dec_neg;
    logic dec_mon_ref;
    logic dec_mon_sup;
    logic dec_valid;
    logic [7:0] next_cfg0;

    // ==========================================================
    // input select decode
    // register 0 after this edge, kept apart from next_state so no false loop forms
    assign next_cfg0 = (i_wr_en && i_wr_addr == ACR_ADDR_INPUT_GAIN) ? i_wr_data
        : state.input_gain_config;

    acr_input_decode u_decode
    (
        .i_sel_code(next_cfg0[ACR_SEL_MSB:ACR_SEL_LSB]),
        .o_pos_input(dec_pos),
        .o_neg_input(dec_neg),
        .o_mon_ref(dec_mon_ref),
        .o_mon_supply(dec_mon_sup),
        .o_sel_valid(dec_valid)
    );

    // normal-mode rate per code, reserved code gives zero
    function automatic logic [10:0] base_sps(input logic [2:0] code);
        logic [10:0] sps;
        case (code)
            3'h0: sps = ACR_SPS_0;
            3'h1: sps = ACR_SPS_1;
            3'h2: sps = ACR_SPS_2;
            3'h3: sps = ACR_SPS_3;
            3'h4: sps = ACR_SPS_4;
            3'h5: sps = ACR_SPS_5;
            3'h6: sps = ACR_SPS_6;
            default: sps = 11'h000;
        endcase
        return sps;
    endfunction

    // ==========================================================
    // next state
    always_comb
    begin
        logic [2:0] gain_raw;
        logic skip;
        logic temp;
        logic [2:0] rate;
        logic [13:0] sps4;
        gain_raw = 3'h0;
        skip = 1'b0;
        temp = 1'b0;
        rate = 3'h0;
        sps4 = 14'h0000;
        next_state = state;
        next_state.restart = 1'b0;
        // registers change only on a decoded write; no power-down clears them
        if (i_wr_en) // R13 R14
        begin
            if (i_wr_addr == ACR_ADDR_INPUT_GAIN)
            begin
                next_state.input_gain_config = i_wr_data; // R12 R17
            end
            else if (i_wr_addr == ACR_ADDR_RATE_MODE)
            begin
                next_state.rate_mode_config = i_wr_data; // R12 R17
            end
        end
        if (i_wr_cmd_done)
        begin
            next_state.restart = 1'b1; // R15
        end
        // read data from the stored bytes; other addresses live elsewhere
        if (i_rd_addr == ACR_ADDR_INPUT_GAIN)
        begin
            next_state.rd_data = state.input_gain_config; // R12
        end
        else if (i_rd_addr == ACR_ADDR_RATE_MODE)
        begin
            next_state.rd_data = state.rate_mode_config; // R12
        end
        else
        begin
            next_state.rd_data = 8'h00;
        end

        gain_raw = next_state.input_gain_config[ACR_GAIN_MSB:ACR_GAIN_LSB];
        skip = next_state.input_gain_config[ACR_SKIP_BIT];
        temp = next_state.rate_mode_config[ACR_TEMP_BIT];
        rate = next_state.rate_mode_config[ACR_RATE_MSB:ACR_RATE_LSB];

        // front end; temperature mode disconnects the inputs and ignores register 0
        if (temp) // R10
        begin
            next_state.pos = 3'h0;
            next_state.neg = 3'h0;
            next_state.mon_ref = 1'b0;
            next_state.mon_sup = 1'b0;
            next_state.in_valid = 1'b0;
            next_state.gain = 3'h0;
            next_state.lna_en = 1'b0;
            next_state.sc_en = 1'b0;
        end
        else
        begin
            next_state.pos = dec_pos; // R1
            next_state.neg = dec_neg;
            next_state.mon_ref = dec_mon_ref; // R2
            next_state.mon_sup = dec_mon_sup;
            next_state.in_valid = dec_valid;
            next_state.gain = gain_raw; // R4
            // ground-referred inputs rely on the host setting skip and a low gain
            if (dec_mon_ref || dec_mon_sup) // R2 R3
            begin
                next_state.lna_en = 1'b0;
            end
            else if (gain_raw > ACR_GAIN_SC_LAST) // R6
            begin
                next_state.lna_en = 1'b1;
            end
            else
            begin
                next_state.lna_en = ~skip; // R6
            end
            next_state.sc_en = ~next_state.lna_en; // R5
        end
        next_state.gain_factor = 8'h01 << next_state.gain; // R4

        // modulator and rate
        next_state.mode = next_state.rate_mode_config[ACR_MODE_MSB:ACR_MODE_LSB]; // R8
        next_state.mode_valid = next_state.mode != ACR_MODE_RSVD; // R8 R17
        next_state.duty = next_state.mode == ACR_MODE_DUTY; // R8
        if (next_state.mode == ACR_MODE_TURBO)
        begin
            next_state.mod_khz = ACR_MOD_KHZ_TURBO; // R8
        end
        else if (next_state.mode_valid)
        begin
            next_state.mod_khz = ACR_MOD_KHZ_NORMAL; // R8
        end
        else
        begin
            next_state.mod_khz = 10'h000;
        end
        // quarter-sps units keep the duty-cycle fractions exact
        sps4 = {1'b0, base_sps(rate), 2'b00};
        next_state.rate_valid = next_state.mode_valid && rate != ACR_GAIN_RESERVED_RATE; // R16 R17
        if (!next_state.rate_valid)
        begin
            next_state.rate_qsps = 14'h0000;
        end
        else if (next_state.mode == ACR_MODE_DUTY) // R7
        begin
            next_state.rate_qsps = {2'b00, sps4[13:2]}; // R16
        end
        else if (next_state.mode == ACR_MODE_TURBO)
        begin
            next_state.rate_qsps = {sps4[12:0], 1'b0}; // R16
        end
        else
        begin
            next_state.rate_qsps = sps4; // R16
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            state <= '0;
            state.input_gain_config <= ACR_RST_INPUT_GAIN; // R12
            state.rate_mode_config <= ACR_RST_RATE_MODE; // R12
            state.gain_factor <= 8'h01;
            state.lna_en <= 1'b1;
            state.in_valid <= 1'b1;
            state.neg <= 3'h1;
            state.mode_valid <= 1'b1;
            state.mod_khz <= ACR_MOD_KHZ_NORMAL;
            state.rate_valid <= 1'b1;
            state.rate_qsps <= 14'h0050;
        end
        else if (i_clk_en)
        begin
            state <= next_state;
        end
    end

    // ==========================================================
    // outputs
    assign o_rd_data = state.rd_data;
    assign o_positive_input = state.pos;
    assign o_negative_input = state.neg;
    assign o_mon_reference = state.mon_ref;
    assign o_mon_analog_supply = state.mon_sup;
    assign o_input_valid = state.in_valid;
    assign o_gain_code = state.gain;
    assign o_gain_factor = state.gain_factor;
    assign o_lna_enable = state.lna_en;
    assign o_sc_gain_enable = state.sc_en;
    assign o_temp_sensor_enable = state.rate_mode_config[ACR_TEMP_BIT]; // R10
    assign o_internal_ref_force = state.rate_mode_config[ACR_TEMP_BIT]; // R10
    assign o_burnout_source_on = state.rate_mode_config[ACR_BURN_BIT]; // R11
    assign o_continuous_select = state.rate_mode_config[ACR_CONT_BIT]; // R9
    assign o_op_mode = state.mode;
    assign o_mode_valid = state.mode_valid;
    assign o_mod_clk_khz = state.mod_khz;
    assign o_duty_cycle = state.duty;
    assign o_rate_select = state.rate_mode_config[ACR_RATE_MSB:ACR_RATE_LSB]; // R7
    assign o_rate_valid = state.rate_valid;
    assign o_rate_qsps = state.rate_qsps;
    assign o_filter_restart = state.restart;
endmodule

// ==== rtl/acr_pkg.sv ====
// package of offsets, fields, codes and rate constants for the config register pair
package acr_pkg;

    // ==========================================================
    // register addresses and reset values
    localparam logic [1:0] ACR_ADDR_INPUT_GAIN = 2'h0;
    localparam logic [1:0] ACR_ADDR_RATE_MODE = 2'h1;
    localparam logic [7:0] ACR_RST_INPUT_GAIN = 8'h00;
    localparam logic [7:0] ACR_RST_RATE_MODE = 8'h00;

    // ==========================================================
    // field positions, register 0
    localparam int ACR_SEL_LSB = 4;
    localparam int ACR_SEL_MSB = 7;
    localparam int ACR_GAIN_LSB = 1;
    localparam int ACR_GAIN_MSB = 3;
    localparam int ACR_SKIP_BIT = 0;

    // ==========================================================
    // field positions, register 1
    localparam int ACR_RATE_LSB = 5;
    localparam int ACR_RATE_MSB = 7;
    localparam int ACR_MODE_LSB = 3;
    localparam int ACR_MODE_MSB = 4;
    localparam int ACR_CONT_BIT = 2;
    localparam int ACR_TEMP_BIT = 1;
    localparam int ACR_BURN_BIT = 0;

    // ==========================================================
    // input select codes
    localparam logic [3:0] ACR_SEL_DIFF_LAST = 4'h7;
    localparam logic [3:0] ACR_SEL_GND_LAST = 4'hB;
    localparam logic [3:0] ACR_SEL_MON_REF = 4'hC;
    localparam logic [3:0] ACR_SEL_MON_SUPPLY = 4'hD;
    // negative-input code meaning analog ground
    localparam logic [2:0] ACR_NEG_GROUND = 3'h4;
    // highest gain code that the switched-capacitor stage can realise (gain 4)
    localparam logic [2:0] ACR_GAIN_SC_LAST = 3'h2;
    localparam logic [2:0] ACR_GAIN_RESERVED_RATE = 3'h7;

    // ==========================================================
    // operating modes
    typedef enum logic [1:0] {
        ACR_MODE_NORMAL = 2'b00,
        ACR_MODE_DUTY = 2'b01,
        ACR_MODE_TURBO = 2'b10,
        ACR_MODE_RSVD = 2'b11
    } acr_mode_t;

    // modulator clock in kHz per mode
    localparam logic [9:0] ACR_MOD_KHZ_NORMAL = 10'd256;
    localparam logic [9:0] ACR_MOD_KHZ_TURBO = 10'd512;

    // normal-mode rates in samples per second, codes 0 to 6
    localparam logic [10:0] ACR_SPS_0 = 11'd20;
    localparam logic [10:0] ACR_SPS_1 = 11'd45;
    localparam logic [10:0] ACR_SPS_2 = 11'd90;
    localparam logic [10:0] ACR_SPS_3 = 11'd175;
    localparam logic [10:0] ACR_SPS_4 = 11'd330;
    localparam logic [10:0] ACR_SPS_5 = 11'd600;
    localparam logic [10:0] ACR_SPS_6 = 11'd1000;

endpackage

// ==== rtl/acr_input_decode.sv ====
// input-select code decoder for the analog front end
`timescale 1ns/1ps
module acr_input_decode
(
    input wire logic [3:0] i_sel_code,   // input_select field
    output logic [2:0] o_pos_input,      // positive input index 0..3
    output logic [2:0] o_neg_input,      // negative input index, 4 = analog ground
    output logic o_mon_ref,              // reference difference / 4 monitor
    output logic o_mon_supply,           // analog supply / 4 monitor
    output logic o_sel_valid             // code is a defined selection
);
    import acr_pkg::*;

    // ==========================================================
    // decode
    always_comb
    begin
        o_pos_input = 3'h0;
        o_neg_input = 3'h0;
        o_mon_ref = 1'b0;
        o_mon_supply = 1'b0;
        o_sel_valid = 1'b1;
        if (i_sel_code <= ACR_SEL_DIFF_LAST)
        begin
            case (i_sel_code[2:0]) // R1
                3'h0: begin o_pos_input = 3'h0; o_neg_input = 3'h1; end
                3'h1: begin o_pos_input = 3'h0; o_neg_input = 3'h2; end
                3'h2: begin o_pos_input = 3'h0; o_neg_input = 3'h3; end
                3'h3: begin o_pos_input = 3'h1; o_neg_input = 3'h2; end
                3'h4: begin o_pos_input = 3'h1; o_neg_input = 3'h3; end
                3'h5: begin o_pos_input = 3'h2; o_neg_input = 3'h3; end
                3'h6: begin o_pos_input = 3'h1; o_neg_input = 3'h0; end
                default: begin o_pos_input = 3'h3; o_neg_input = 3'h2; end
            endcase
        end
        else if (i_sel_code <= ACR_SEL_GND_LAST)
        begin
            o_pos_input = {1'b0, i_sel_code[1:0]}; // R1
            o_neg_input = ACR_NEG_GROUND;
        end
        else if (i_sel_code == ACR_SEL_MON_REF)
        begin
            o_mon_ref = 1'b1; // R2
        end
        else if (i_sel_code == ACR_SEL_MON_SUPPLY)
        begin
            o_mon_supply = 1'b1; // R2
        end
        else
        begin
            // 1110 and 1111 route nothing
            o_sel_valid = 1'b0; // R2 R17
        end
    end
endmodule

// ==== verification/acr_config_regs_assertions.sv ====
// checker of the config register pair outputs
`timescale 1ns/1ps
module acr_config_regs_chk
import acr_pkg::*;
(
    input wire logic i_sys_clk, // clock
    input wire logic i_reset, // reset
    input wire logic i_clk_en, // enable
    input wire logic i_wr_en, // write strobe
    input wire logic [1:0] i_wr_addr, // write address
    input wire logic [7:0] i_wr_data, // write byte
    input wire logic i_wr_cmd_done, // command end
    input wire logic [1:0] i_rd_addr, // read address
    input wire logic [7:0] o_rd_data, // read data
    input wire logic o_mon_reference, // ref monitor
    input wire logic o_mon_analog_supply, // supply monitor
    input wire logic o_input_valid, // front end valid
    input wire logic [2:0] o_gain_code, // gain code
    input wire logic [7:0] o_gain_factor, // gain
    input wire logic o_lna_enable, // amplifier on
    input wire logic o_sc_gain_enable, // sc gain
    input wire logic o_temp_sensor_enable, // temp mode
    input wire logic o_internal_ref_force, // internal ref
    input wire logic o_burnout_source_on, // burn-out
    input wire logic o_continuous_select, // continuous
    input wire logic [1:0] o_op_mode, // mode
    input wire logic [9:0] o_mod_clk_khz, // modulator clock
    input wire logic [2:0] o_rate_select, // rate code
    input wire logic o_rate_valid, // rate valid
    input wire logic [13:0] o_rate_qsps, // rate
    input wire logic o_filter_restart // restart
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    // ==========================================
    // write and read sequences
    sequence s_wr0;
        i_clk_en && i_wr_en && i_wr_addr == ACR_ADDR_INPUT_GAIN;
    endsequence
    sequence s_wr1;
        i_clk_en && i_wr_en && i_wr_addr == ACR_ADDR_RATE_MODE;
    endsequence
    sequence s_rd0;
        i_clk_en && i_rd_addr == ACR_ADDR_INPUT_GAIN;
    endsequence
    // ==========================================
    // properties
    AST_WR_FIELDS:
    assert property (s_wr1 |=> {o_rate_select, o_op_mode, o_continuous_select,
        o_temp_sensor_enable, o_burnout_source_on} == $past(i_wr_data))
        else $error("reg1 fields do not follow write");
    AST_WR_READ:
    assert property (s_wr0 ##1 s_rd0 |=> o_rd_data == $past(i_wr_data, 2))
        else $error("reg0 readback differs");
    AST_RESTART:
    assert property (i_clk_en && i_wr_cmd_done |=> o_filter_restart)
        else $error("no restart after command");
    AST_RESTART_ONE:
    assert property (i_clk_en && !i_wr_cmd_done |=> !o_filter_restart)
        else $error("restart without command");
    AST_GAIN_POW:
    assert property (o_gain_factor == (8'h01 << o_gain_code))
        else $error("gain factor wrong");
    AST_LNA_HIGH:
    assert property (!o_temp_sensor_enable && !o_mon_reference && !o_mon_analog_supply
        && o_gain_code > ACR_GAIN_SC_LAST |-> o_lna_enable)
        else $error("amplifier off at high gain");
    AST_MON:
    assert property (o_mon_reference || o_mon_analog_supply |-> !o_lna_enable)
        else $error("monitor without bypass");
    AST_SC:
    assert property (!o_temp_sensor_enable |-> o_sc_gain_enable == !o_lna_enable)
        else $error("gain stage choice wrong");
    AST_TEMP:
    assert property (o_temp_sensor_enable |-> o_internal_ref_force && !o_input_valid
        && !o_lna_enable && !o_sc_gain_enable)
        else $error("temp mode decode wrong");
    AST_KHZ:
    assert property (o_mod_clk_khz == (o_op_mode == ACR_MODE_TURBO ? ACR_MOD_KHZ_TURBO
        : o_op_mode == ACR_MODE_RSVD ? 10'h000 : ACR_MOD_KHZ_NORMAL))
        else $error("modulator clock wrong");
    AST_RSVD:
    assert property (o_op_mode == ACR_MODE_RSVD || o_rate_select == ACR_GAIN_RESERVED_RATE
        |-> !o_rate_valid && o_rate_qsps == 14'h0000)
        else $error("reserved code used as rate");
    AST_FREEZE:
    assert property (!i_clk_en |=> $stable(o_rd_data) && $stable(o_filter_restart))
        else $error("state moved while frozen");
    AST_RST:
    assert property (disable iff (1'b0) i_reset |=> o_rd_data == 8'h00
        && o_rate_qsps == 14'h0050)
        else $error("reset values wrong");
endmodule
bind acr_config_regs acr_config_regs_chk chk (.*);

// ==== verification/acr_host_model.sv ====
// host-side model issuing register commands to the config pair
`timescale 1ns/1ps
module acr_host_model
(
    input wire logic i_sys_clk, // clock
    input wire logic [7:0] i_rd_data, // read data
    output logic o_wr_en, // byte strobe
    output logic [1:0] o_wr_addr, // byte address
    output logic [7:0] o_wr_data, // byte
    output logic o_wr_cmd_done, // command end
    output logic [1:0] o_rd_addr // read address
);
    initial
    begin
        o_wr_en = 1'b0;
        o_wr_addr = 2'h0;
        o_wr_data = 8'h00;
        o_wr_cmd_done = 1'b0;
        o_rd_addr = 2'h0;
    end
    // ==========================================
    // command tasks
    task automatic write(input logic [1:0] a, input logic [7:0] d, input logic done);
        logic [7:0] v;
        v = d;
        // ground-referred inputs: skip on, gain at most 2
        if (a == 2'h0 && d[7:6] == 2'b10)
        begin
            v[0] = 1'b1;
            v[3:2] = 2'b00;
        end
        @(posedge i_sys_clk);
        o_wr_en <= 1'b1;
        o_wr_addr <= a;
        o_wr_data <= v;
        o_wr_cmd_done <= done;
        @(posedge i_sys_clk);
        o_wr_en <= 1'b0;
        o_wr_cmd_done <= 1'b0;
        // released byte lines must not look valid
        o_wr_data <= ~v;
        #1;
    endtask
    task automatic read(input logic [1:0] a, output logic [7:0] d);
        @(posedge i_sys_clk);
        o_rd_addr <= a;
        @(posedge i_sys_clk);
        #1;
        d = i_rd_data;
    endtask
endmodule

// ==== verification/adc_config_regs_zero_one_bench.sv ====
// self-checking bench of the config register pair
`timescale 1ns/1ps
module adc_config_regs_zero_one_bench;
import acr_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_clk_en = 1'b1;
    logic i_wr_en, i_wr_cmd_done, o_mon_reference, o_mon_analog_supply, o_input_valid;
    logic o_lna_enable, o_sc_gain_enable, o_temp_sensor_enable, o_internal_ref_force;
    logic o_burnout_source_on, o_continuous_select, o_mode_valid, o_duty_cycle;
    logic o_rate_valid, o_filter_restart;
    logic [1:0] i_wr_addr, i_rd_addr, o_op_mode;
    logic [2:0] o_positive_input, o_negative_input, o_gain_code, o_rate_select;
    logic [7:0] i_wr_data, o_rd_data, o_gain_factor, d;
    logic [9:0] o_mod_clk_khz;
    logic [13:0] o_rate_qsps;
    int bad_count = 0;
    int tests_run = 0;
    logic [2:0] pos_tab [12] = '{0, 0, 0, 1, 1, 2, 1, 3, 0, 1, 2, 3};
    logic [2:0] neg_tab [12] = '{1, 2, 3, 2, 3, 3, 0, 2, 4, 4, 4, 4};
    logic [13:0] sps_tab [8] = '{ACR_SPS_0, ACR_SPS_1, ACR_SPS_2, ACR_SPS_3, ACR_SPS_4,
        ACR_SPS_5, ACR_SPS_6, 0};
    always #2.5 i_sys_clk = ~i_sys_clk;
    acr_config_regs dut (.*);
    acr_host_model host (.i_sys_clk(i_sys_clk), .i_rd_data(o_rd_data), .o_wr_en(i_wr_en),
        .o_wr_addr(i_wr_addr), .o_wr_data(i_wr_data), .o_wr_cmd_done(i_wr_cmd_done),
        .o_rd_addr(i_rd_addr));
    // ==========================================
    // shared checks
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check_defaults(input string n);
        host.read(2'h0, d);
        chk("rd0", 8'h00, d);
        host.read(2'h1, d);
        chk("rd1", 8'h00, d);
        chk("neg", 3'h1, o_negative_input);
        chk("factor", 8'h01, o_gain_factor);
        chk("lna", 1'b1, o_lna_enable);
        chk("qsps", 14'h0050, o_rate_qsps);
        chk("khz", ACR_MOD_KHZ_NORMAL, o_mod_clk_khz);
        $display("%s done", n);
    endtask
    // ==========================================
    // scenarios
    task automatic test_inputs();
        for (int c = 0; c < 16; c++)
        begin
            host.write(2'h0, {c[3:0], 4'h1}, 1'b0);
            if (c < 12)
            begin
                chk("pos", pos_tab[c], o_positive_input);
                chk("neg", neg_tab[c], o_negative_input);
            end
            chk("mon_ref", c == 12, o_mon_reference);
            chk("mon_sup", c == 13, o_mon_analog_supply);
            chk("valid", c < 14, o_input_valid);
            chk("lna", 1'b0, o_lna_enable);
            host.read(2'h0, d);
            chk("rd0", {c[3:0], 4'h1}, d);
        end
        $display("inputs done");
    endtask
    task automatic test_gain();
        for (int g = 0; g < 8; g++)
            for (int s = 0; s < 2; s++)
            begin
                host.write(2'h0, {4'h0, g[2:0], s[0]}, 1'b0);
                chk("factor", 16'h0001 << g, o_gain_factor);
                chk("lna", g > 2 || s == 0, o_lna_enable);
                chk("sc", !(g > 2 || s == 0), o_sc_gain_enable);
            end
        $display("gain done");
    endtask
    task automatic test_rates();
        logic v;
        for (int m = 0; m < 4; m++)
            for (int r = 0; r < 8; r++)
            begin
                host.write(2'h1, {r[2:0], m[1:0], r[0], 1'b0, m[0]}, 1'b0);
                v = m != 3 && r != 7;
                chk("khz", m == 2 ? 512 : m == 3 ? 0 : 256, o_mod_clk_khz);
                chk("duty", m == 1, o_duty_cycle);
                chk("mvalid", m != 3, o_mode_valid);
                chk("rvalid", v, o_rate_valid);
                chk("qsps", v ? sps_tab[r] * (m == 0 ? 4 : m == 1 ? 1 : 8) : 0,
                    o_rate_qsps);
                chk("cont", r[0], o_continuous_select);
                chk("burn", m[0], o_burnout_source_on);
                host.read(2'h1, d);
                chk("rd1", {r[2:0], m[1:0], r[0], 1'b0, m[0]}, d);
            end
        $display("rates done");
    endtask
    task automatic test_temp();
        host.write(2'h0, 8'h3F, 1'b0);
        host.write(2'h1, 8'h02, 1'b0);
        chk("ref", 1'b1, o_internal_ref_force);
        chk("valid", 1'b0, o_input_valid);
        chk("gain", 3'h0, o_gain_code);
        host.read(2'h0, d);
        chk("rd0", 8'h3F, d);
        host.write(2'h1, 8'h00, 1'b0);
        chk("gain", 3'h7, o_gain_code);
        chk("ref", 1'b0, o_internal_ref_force);
        host.write(2'h3, 8'hFF, 1'b0);
        host.read(2'h1, d);
        chk("rd1", 8'h00, d);
        host.read(2'h3, d);
        chk("rd3", 8'h00, d);
        $display("temp done");
    endtask
    task automatic test_restart();
        host.write(2'h1, 8'h14, 1'b1);
        chk("restart", 1'b1, o_filter_restart);
        chk("qsps", 14'h00A0, o_rate_qsps);
        @(posedge i_sys_clk);
        #1;
        chk("restart", 1'b0, o_filter_restart);
        @(posedge i_sys_clk);
        i_clk_en <= 1'b0;
        host.write(2'h1, 8'h00, 1'b1);
        chk("frozen", 2'h2, o_op_mode);
        chk("restart", 1'b0, o_filter_restart);
        @(posedge i_sys_clk);
        i_clk_en <= 1'b1;
        $display("restart done");
    endtask
    task automatic test_mid_reset();
        host.write(2'h0, 8'h5A, 1'b0);
        @(posedge i_sys_clk);
        i_reset <= 1'b1;
        @(posedge i_sys_clk);
        i_reset <= 1'b0;
        check_defaults("mid reset");
    endtask
    // ==========================================
    // main sequence and watchdog
    initial
    begin
        repeat (3) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        check_defaults("reset");
        test_inputs();
        test_gain();
        test_rates();
        test_temp();
        test_restart();
        test_mid_reset();
        final_report();
    end
    initial
    begin
        #50000;
        bad_count++;
        final_report();
    end
endmodule
